// file: logic/cmas_pkg.sv
// Package for the clock mode auto-switch block: offsets, fields, constants
// Contract
// - With the reload-inhibit bit at 0 a stop release reloads timer and prescaler; at 1 they are left alone.
// - The stabilization reload writes FF to the prescaler that feeds the first timer.
// - The stabilization reload writes 01 to the first timer together with the prescaler.
// - A pin interrupt may start an automatic switch only while the switch enable bit is 1.
// - The wait select bit picks a settling wait of 4.5 to 5.5 machine cycles at 0 and 6.5 to 7.5 at 1.
// - Writing 1 to the program start bit launches a switch and writing 0 does nothing.
// - The program start request is honoured only in low-speed mode.
// - A pin-interrupt switch takes effect only in low-speed mode.
// - A completed switch updates the CPU mode register to middle-speed mode.
// - The upper four bits of the misc clock control register ignore writes and read 0.
// - The timing field sets release time to (field+1) clocks and set-up and hold to (field+1)/2.
// - The polarity bit selects falling edges at 0 and rising edges at 1.
// - The line select bit takes SDA at 0 and SCL at 1.
// - Polarity sits at bit 5 and line select at bit 6 of the condition register.
package cmas_pkg;
	localparam logic [7:0] COND_CTRL_OFS  = 8'h30;
	localparam logic [7:0] MISC_CTRL_OFS  = 8'h38;
	localparam logic [7:0] CPU_MODE_OFS   = 8'h3B;
	localparam logic [7:0] IRQ_STAT_OFS   = 8'h40;
	localparam logic [7:0] IRQ_MASK_OFS   = 8'h44;
	localparam logic [7:0] MISC_RST       = 8'h00;
	localparam logic [7:0] COND_RST       = 8'h00;
	localparam logic [7:0] PRESC_RELOAD   = 8'hFF;
	localparam logic [7:0] TIMER_RELOAD   = 8'h01;
	localparam int BIT_NO_RELOAD = 0;
	localparam int BIT_SW_EN     = 1;
	localparam int BIT_WAIT_SEL  = 2;
	localparam int BIT_SW_START  = 3;
	localparam int BIT_POL       = 5;
	localparam int BIT_LINE      = 6;
	localparam int SSC_W         = 5;
	localparam logic [7:0] MISC_WMASK = 8'h0F;
	localparam logic [7:0] COND_WMASK = 8'h7F;
	// Machine cycle length in clocks; waits are 5 and 7 machine cycles
	localparam int MC_CLKS        = 2;
	localparam int WAIT_SHORT_MC  = 5;
	localparam int WAIT_LONG_MC   = 7;
	localparam logic [7:0] WAIT_SHORT = 8'(WAIT_SHORT_MC * MC_CLKS);
	localparam logic [7:0] WAIT_LONG  = 8'(WAIT_LONG_MC * MC_CLKS);
	// CPU clock mode codes
	typedef enum logic [1:0] {MODE_HIGH, MODE_MID, MODE_LOW, MODE_RSV} cmas_mode_t;
	typedef enum {ST_IDLE, ST_WAIT} cmas_state_t;
	// Interrupt status bits
	localparam int IRQ_SW_DONE = 0;
	localparam int IRQ_PIN     = 1;
	typedef struct packed {
		logic [7:0] timer;
		logic [7:0] presc;
		logic       load;
	} cmas_reload_t;
endpackage : cmas_pkg

// file: logic/cmas_top.sv
// Clock mode auto-switch and stop-release reload with Wishbone registers
`timescale 1ns/10ps
`default_nettype none
module cmas_top
	import cmas_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [7:0]         wb_adr_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic      [31:0]        wb_dat_o,
	output logic                    wb_ack_o,
	input  wire logic               scl_i,
	input  wire logic               sda_i,
	input  wire logic               stop_release_i,
	input  wire logic               osc_ready_i,
	output logic                    main_osc_en_o,
	output logic      [1:0]         clk_mode_o,
	output cmas_reload_t            reload_o,
	output logic      [SSC_W-1:0]   release_clks_o,
	output logic      [SSC_W-1:0]   setup_hold_clks_o,
	output logic                    irq_o
);
	// Pin synchronisers: stage one feeds only stage two
	logic [1:0] scl_s, sda_s;
	logic       line_q;
	logic [7:0] misc, next_misc, cond, next_cond;
	logic [1:0] mode, next_mode;
	logic [1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
	logic       ack, next_ack;
	logic [31:0] rdat, next_rdat;
	cmas_state_t state, next_state;
	logic [7:0] cnt, next_cnt;
	cmas_reload_t rel, next_rel;
	logic       sel_line, pin_edge, wr, rd, sw_req, pin_req;

	function automatic logic [7:0] lane_merge(input logic [7:0] old,
		input logic [7:0] nw, input logic [7:0] wmask);
		lane_merge = (old & ~wmask) | (nw & wmask);
	endfunction : lane_merge

	// Source and edge select for the pin interrupt
	always_comb begin
		sel_line = cond[BIT_LINE] ? scl_s[1] : sda_s[1];
		pin_edge = cond[BIT_POL] ? (sel_line & ~line_q)
			: (~sel_line & line_q);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_s  <= 2'h3;
			sda_s  <= 2'h3;
			line_q <= 1'b1;
		end else begin
			scl_s  <= {scl_s[0], scl_i};
			sda_s  <= {sda_s[0], sda_i};
			line_q <= sel_line;
		end
	end

	// Bus strobes; ack drops the cycle after it rose
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack & wb_sel_i[0];
	assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack;
	assign sw_req = wr && wb_adr_i == MISC_CTRL_OFS
		&& wb_dat_i[BIT_SW_START];
	assign pin_req = pin_edge & misc[BIT_SW_EN];

	// Registers, switch sequence and reload
	always_comb begin
		next_misc     = misc;
		next_cond     = cond;
		next_mode     = mode;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;
		next_state    = state;
		next_cnt      = cnt;
		next_rel      = rel;
		next_rel.load = 1'b0;
		next_ack      = wb_cyc_i & wb_stb_i & ~ack;
		next_rdat     = 32'h0000_0000;
		if (wr) begin
			unique case (wb_adr_i)
				MISC_CTRL_OFS: next_misc = lane_merge(misc,
					wb_dat_i[7:0], MISC_WMASK);
				// Bit 7 is held at 0 so a stray write cannot set it
				COND_CTRL_OFS: next_cond = lane_merge(cond,
					wb_dat_i[7:0], COND_WMASK);
				CPU_MODE_OFS:  next_mode = wb_dat_i[1:0];
				IRQ_MASK_OFS:  next_irq_mask = wb_dat_i[1:0];
				IRQ_STAT_OFS:  next_irq_stat = irq_stat & ~wb_dat_i[1:0];
				default: ;
			endcase
		end
		if (rd) begin
			unique case (wb_adr_i)
				MISC_CTRL_OFS: next_rdat = {28'h0, misc[3:0]};
				COND_CTRL_OFS: next_rdat = {24'h0, cond};
				CPU_MODE_OFS:  next_rdat = {30'h0, mode};
				IRQ_MASK_OFS:  next_rdat = {30'h0, irq_mask};
				IRQ_STAT_OFS:  next_rdat = {30'h0, irq_stat};
				default:       next_rdat = 32'h0000_0000;
			endcase
		end
		if (pin_edge)
			next_irq_stat[IRQ_PIN] = 1'b1; // set wins over clear
		// Stop release reload unless inhibited
		if (stop_release_i && !misc[BIT_NO_RELOAD]) begin
			next_rel.presc = PRESC_RELOAD;
			next_rel.timer = TIMER_RELOAD;
			next_rel.load  = 1'b1;
		end
		unique case (state)
			ST_IDLE: begin
				// Only low-speed mode may start a switch
				if ((sw_req || pin_req) && mode == MODE_LOW) begin
					next_state = ST_WAIT;
					next_cnt   = misc[BIT_WAIT_SEL] ? WAIT_LONG
						: WAIT_SHORT;
				end
			end
			ST_WAIT: begin
				// Counter runs only once the oscillator reports running
				if (osc_ready_i && cnt != 8'h00)
					next_cnt = cnt - 8'h01;
				if (cnt == 8'h00) begin
					next_state = ST_IDLE;
					next_mode  = MODE_MID;
					next_irq_stat[IRQ_SW_DONE] = 1'b1;
				end
			end
		endcase
		// Start bit is self-clearing: it reads 0 after the write
		next_misc[BIT_SW_START] = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			misc     <= MISC_RST;
			cond     <= COND_RST;
			mode     <= MODE_LOW;
			irq_stat <= 2'h0;
			irq_mask <= 2'h0;
			ack      <= 1'b0;
			rdat     <= 32'h0000_0000;
			state    <= ST_IDLE;
			cnt      <= 8'h00;
			rel      <= '0;
		end else begin
			misc     <= next_misc;
			cond     <= next_cond;
			mode     <= next_mode;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			ack      <= next_ack;
			rdat     <= next_rdat;
			state    <= next_state;
			cnt      <= next_cnt;
			rel      <= next_rel;
		end
	end

	// Outputs; timing counts are the field (release clocks minus one) and (field+1)/2 clocks
	assign wb_ack_o      = ack;
	assign wb_dat_o      = rdat;
	assign clk_mode_o    = mode;
	assign main_osc_en_o = (state == ST_WAIT) || (mode != MODE_LOW);
	assign reload_o      = rel;
	assign release_clks_o    = cond[SSC_W-1:0]; // add one for clocks
	assign setup_hold_clks_o = 5'((6'(cond[SSC_W-1:0]) + 6'h01) >> 1);
	assign irq_o         = |(irq_stat & irq_mask);
endmodule : cmas_top
`default_nettype wire

// file: test/cmas_top_assertions.sv
// Port assertions for the clock mode auto-switch block
`timescale 1ns/10ps
`default_nettype none
module cmas_chk
	import cmas_pkg::*;
(
	input wire logic             clk_i,
	input wire logic             rst_i,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_ack_o,
	input wire logic             stop_release_i,
	input wire logic             main_osc_en_o,
	input wire logic [1:0]       clk_mode_o,
	input wire cmas_reload_t     reload_o,
	input wire logic [SSC_W-1:0] release_clks_o,
	input wire logic [SSC_W-1:0] setup_hold_clks_o,
	input wire logic             irq_o
);
	default clocking @(posedge clk_i); endclocking
	// Bus answers one cycle late and for one cycle only
	property p_ack;
		disable iff (rst_i) wb_cyc_i && wb_stb_i && !wb_ack_o
			|=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack timing wrong");
	property p_idle;
		disable iff (rst_i) !wb_stb_i |=> !wb_ack_o;
	endproperty
	a_idle: assert property (p_idle) else $error("ack without request");
	// Reload pulse carries the fixed values and follows a stop release
	property p_reload;
		disable iff (rst_i) reload_o.load |-> reload_o.timer == TIMER_RELOAD
			&& reload_o.presc == PRESC_RELOAD;
	endproperty
	a_reload: assert property (p_reload) else $error("reload values wrong");
	property p_cause;
		disable iff (rst_i) reload_o.load |-> $past(stop_release_i);
	endproperty
	a_cause: assert property (p_cause) else $error("reload without release");
	property p_one;
		disable iff (rst_i) reload_o.load |=> !reload_o.load;
	endproperty
	a_one: assert property (p_one) else $error("reload pulse too long");
	// Set-up and hold are half of the release time, rounded down
	property p_timing;
		disable iff (rst_i) setup_hold_clks_o
			== SSC_W'((6'(release_clks_o) + 6'h01) >> 1);
	endproperty
	a_timing: assert property (p_timing) else $error("set-up time wrong");
	// An automatic move to middle speed needs the oscillator already up
	property p_osc;
		disable iff (rst_i) (clk_mode_o == MODE_MID && $past(clk_mode_o)
			== MODE_LOW && !wb_ack_o && !$past(wb_ack_o))
			|-> $past(main_osc_en_o, 2);
	endproperty
	a_osc: assert property (p_osc) else $error("switch before osc start");
	// Reset leaves the block in low-speed mode and quiet
	property p_rst;
		$fell(rst_i) |-> clk_mode_o == MODE_LOW && !irq_o && !reload_o.load;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : cmas_chk
`default_nettype wire

// file: test/tb_cmas_top.sv
// Self-checking bench for the clock mode auto-switch block
`timescale 1ns/10ps
`default_nettype none
module tb_cmas_top
	import cmas_pkg::*;
;
	logic         clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
	logic         we = 1'b0, scl = 1'b1, sda = 1'b1, rel = 1'b0;
	logic         osc = 1'b1;
	logic [7:0]   adr = 8'h00, q;
	logic [31:0]  dat = 32'h0, rdat;
	logic         ack, osc_en, irq;
	logic [1:0]   mode;
	cmas_reload_t rl;
	logic [4:0]   rcl, shc;
	int           failures = 0, checks = 0, loads = 0, n;
	// Rows: address, write value, expected read back
	localparam logic [23:0] ROWS [4] = '{{MISC_CTRL_OFS, 8'hF7, 8'h07},
		{COND_CTRL_OFS, 8'h7F, 8'h7F}, 24'h50A500, {IRQ_MASK_OFS, 8'h03, 8'h03}};
	always #5 clk_i = ~clk_i;
	cmas_top i_cmas_top(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl),
		.sda_i(sda), .stop_release_i(rel), .osc_ready_i(osc),
		.main_osc_en_o(osc_en), .clk_mode_o(mode), .reload_o(rl),
		.release_clks_o(rcl), .setup_hold_clks_o(shc), .irq_o(irq));
	// Count reload pulses seen at the port
	always @(posedge clk_i) if (rl.load === 1'b1) loads++;
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Classic cycle: hold everything until ack is sampled, then release
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, 24'h0, d};
		n = 0;
		do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
		q = rdat[7:0];
		{cyc, stb} <= 2'b00;
	endtask : bus
	task automatic wait_mode(input int lo, input int hi);
		n = 0;
		while (mode !== MODE_MID && n < 60) begin @(posedge clk_i); n++; end
		chk(8'(n >= lo && n <= hi), 8'h01);
	endtask : wait_mode
	task automatic stop_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		failures++;
		stop_test();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(MISC_CTRL_OFS, 1'b0, 8'h00);
		chk(q, MISC_RST);
		chk(8'(mode), 8'(MODE_LOW));
		$display("reset test done");
		foreach (ROWS[i]) begin
			bus(ROWS[i][23:16], 1'b1, ROWS[i][15:8]);
			bus(ROWS[i][23:16], 1'b0, 8'h00);
			chk(q, ROWS[i][7:0]);
		end
		chk({3'h0, rcl}, 8'h1F);
		chk({3'h0, shc}, 8'h10);
		$display("table test done");
		// Stop release with reload inhibited, then allowed
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_i) rel <= 1'b1;
			@(posedge clk_i) rel <= 1'b0;
			repeat (4) @(posedge clk_i);
			chk(8'(loads), 8'(k));
			bus(MISC_CTRL_OFS, 1'b1, 8'h00);
		end
		bus(MISC_CTRL_OFS, 1'b1, 8'h08);
		wait_mode(WAIT_SHORT, WAIT_SHORT + 3);
		bus(CPU_MODE_OFS, 1'b0, 8'h00);
		chk(q, 8'h01);
		chk(8'(irq), 8'h01);
		bus(IRQ_STAT_OFS, 1'b1, 8'h03);
		chk(8'(irq), 8'h00);
		bus(CPU_MODE_OFS, 1'b1, 8'h00);
		bus(MISC_CTRL_OFS, 1'b1, 8'h08);
		bus(CPU_MODE_OFS, 1'b1, 8'h02);
		bus(MISC_CTRL_OFS, 1'b1, 8'h04);
		repeat (20) @(posedge clk_i);
		chk(8'(mode), 8'(MODE_LOW));
		// Oscillator held back: the wait must not count until it runs
		osc <= 1'b0;
		bus(MISC_CTRL_OFS, 1'b1, 8'h0C);
		repeat (6) @(posedge clk_i);
		chk(8'(mode), 8'(MODE_LOW));
		chk(8'(osc_en), 8'h01);
		osc <= 1'b1;
		wait_mode(WAIT_LONG, WAIT_LONG + 3);
		$display("program switch test done");
		// Pin edges: wrong line, right line while disabled, then enabled
		bus(CPU_MODE_OFS, 1'b1, 8'h02);
		bus(COND_CTRL_OFS, 1'b1, 8'h00);
		bus(MISC_CTRL_OFS, 1'b1, 8'h00);
		bus(IRQ_STAT_OFS, 1'b1, 8'h03);
		scl <= 1'b0;
		bus(IRQ_STAT_OFS, 1'b0, 8'h00);
		chk(q, 8'h00);
		sda <= 1'b0;
		repeat (20) @(posedge clk_i);
		bus(IRQ_STAT_OFS, 1'b0, 8'h00);
		chk(q, 8'h02);
		chk(8'(mode), 8'(MODE_LOW));
		bus(COND_CTRL_OFS, 1'b1, 8'h60);
		sda <= 1'b1;
		bus(MISC_CTRL_OFS, 1'b1, 8'h02);
		scl <= 1'b1;
		wait_mode(WAIT_SHORT, WAIT_SHORT + 8);
		$display("pin switch test done");
		stop_test();
	end
endmodule : tb_cmas_top
bind cmas_top cmas_chk i_cmas_chk(.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.stop_release_i(stop_release_i), .main_osc_en_o(main_osc_en_o),
	.clk_mode_o(clk_mode_o), .reload_o(reload_o),
	.release_clks_o(release_clks_o), .setup_hold_clks_o(setup_hold_clks_o),
	.irq_o(irq_o));
`default_nettype wire
